// [rtl/dma_arb_pkg.sv]
package dma_arb_pkg;
  localparam int NUM_CH = 32;
  localparam int ADDR_W = 8;
  // Register byte offsets on the plain register port.
  localparam logic [7:0] OFF_ENA_SET = 8'h00;
  localparam logic [7:0] OFF_ENA_CLR = 8'h04;
  localparam logic [7:0] OFF_PRIO_SET = 8'h08;
  localparam logic [7:0] OFF_PRIO_CLR = 8'h0C;
  localparam logic [7:0] OFF_BURST_SET = 8'h10;
  localparam logic [7:0] OFF_BURST_CLR = 8'h14;
  localparam logic [7:0] OFF_MASK_SET = 8'h18;
  localparam logic [7:0] OFF_MASK_CLR = 8'h1C;
  localparam logic [7:0] OFF_SW_REQ = 8'h20;
  localparam logic [7:0] OFF_DONE = 8'h24;
  localparam logic [7:0] OFF_CH_SEL = 8'h28;
  localparam logic [7:0] OFF_CH_SRC = 8'h2C;
  localparam logic [7:0] OFF_CH_DST = 8'h30;
  localparam logic [7:0] OFF_CH_CTRL = 8'h34;
  localparam logic [7:0] OFF_STATUS = 8'h38;
  // Channel control word layout.
  localparam int CTL_DSIZE_LSB = 0;
  localparam int CTL_SINC_LSB = 2;
  localparam int CTL_DINC_LSB = 4;
  localparam int CTL_ARB_LSB = 6;
  localparam int CTL_ARB_W = 10;
  localparam int CTL_CNT_LSB = 16;
  localparam int CTL_CNT_W = 11;
  // Item size and address step encodings.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] INC_BYTE = 2'h0;
  localparam logic [1:0] INC_HALF = 2'h1;
  localparam logic [1:0] INC_WORD = 2'h2;
  localparam logic [1:0] INC_NONE = 2'h3;
  // Reset values and the one-item count.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0] RST_CH = 5'h00;
  localparam logic [10:0] RST_CNT = 11'h000;
  localparam logic [10:0] ONE_ITEM = 11'h001;
endpackage : dma_arb_pkg

// [rtl/dma_channel_arbiter.sv]
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module dma_channel_arbiter #(
  parameter int NUM_CH = dma_arb_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_CH-1:0] single_req,
  input wire logic [NUM_CH-1:0] burst_req,
  input wire logic cpu_bus_req,
  output logic dma_bus_valid,
  output logic [31:0] dma_src_addr,
  output logic [31:0] dma_dst_addr,
  output logic [1:0] dma_size,
  output logic [4:0] dma_channel,
  output logic [NUM_CH-1:0] done_pulse
);
  typedef enum logic {ST_IDLE, ST_RUN} state_t;

  // Lowest set bit index; bit 5 flags an empty vector.
  function automatic logic [5:0] pick_lowest(input logic [NUM_CH-1:0] v);
    logic [5:0] r;
    r = 6'h20;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b0, 5'(i)};
      end
    end
    return r;
  endfunction : pick_lowest

  function automatic logic [31:0] step_of(input logic [1:0] inc);
    logic [31:0] s;
    case (inc)
      dma_arb_pkg::INC_BYTE: s = 32'h0000_0001;
      dma_arb_pkg::INC_HALF: s = 32'h0000_0002;
      dma_arb_pkg::INC_WORD: s = 32'h0000_0004;
      default: s = 32'h0000_0000;
    endcase
    return s;
  endfunction : step_of

  logic [NUM_CH-1:0] single_meta, single_sync, burst_meta, burst_sync;
  logic [NUM_CH-1:0] enable_reg, prio_reg, burst_only_reg, mask_reg, sw_pend_reg, done_reg;
  logic [4:0] ch_sel_reg;
  logic [31:0] src_mem [NUM_CH];
  logic [31:0] dst_mem [NUM_CH];
  logic [31:0] ctl_mem [NUM_CH];
  state_t state_reg;
  logic [31:0] ctl_reg;
  logic [10:0] cnt_reg, burst_left_reg;
  logic [NUM_CH-1:0] eff_req, periph_req, hw_clr, win_onehot;
  logic [5:0] hi_pick, any_pick;
  logic [4:0] win;
  logic grant_fire, move, burst_end, last_item, use_burst, empty_ch;
  logic [NUM_CH-1:0] stale_hold_reg, stale_hold_late_reg;
  logic [10:0] arb_items, win_cnt, next_cnt;

  // Request lines come from peripheral pins on another timing domain.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      single_meta <= '0;
      single_sync <= '0;
      burst_meta <= '0;
      burst_sync <= '0;
    end else begin
      single_meta <= single_req;
      single_sync <= single_meta;
      burst_meta <= burst_req;
      burst_sync <= burst_meta;
    end
  end

  // A pin still shows its old level for two cycles after the last item of a burst.
  // The channel just served ignores its pins until then, so it is never served twice for one need.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stale_hold_reg <= '0;
      stale_hold_late_reg <= '0;
    end else begin
      stale_hold_reg <= burst_end ? (NUM_CH'(1) << dma_channel) : '0;
      stale_hold_late_reg <= stale_hold_reg;
    end
  end

  always_comb begin
    periph_req = ~mask_reg & ~(stale_hold_reg | stale_hold_late_reg)
                 & (burst_sync | (single_sync & ~burst_only_reg));
    eff_req = enable_reg & (periph_req | sw_pend_reg);
    hi_pick = pick_lowest(eff_req & prio_reg);
    any_pick = pick_lowest(eff_req);
    win = hi_pick[5] ? any_pick[4:0] : hi_pick[4:0];
    win_onehot = NUM_CH'(1) << win;
    grant_fire = (state_reg == ST_IDLE) && !any_pick[5];
    // A burst request wins over a single one; a software request acts as a burst.
    use_burst = burst_sync[win] | sw_pend_reg[win];
    arb_items = {1'b0, ctl_mem[win][dma_arb_pkg::CTL_ARB_LSB +: dma_arb_pkg::CTL_ARB_W]}
                + dma_arb_pkg::ONE_ITEM;
    win_cnt = ctl_mem[win][dma_arb_pkg::CTL_CNT_LSB +: dma_arb_pkg::CTL_CNT_W];
    empty_ch = win_cnt == dma_arb_pkg::RST_CNT;
  end

  // The processor always owns the bus; an item moves only in a cycle it leaves idle.
  assign move = (state_reg == ST_RUN) && !cpu_bus_req;
  assign dma_bus_valid = move;
  assign last_item = cnt_reg == dma_arb_pkg::ONE_ITEM;
  assign burst_end = move && (burst_left_reg == dma_arb_pkg::ONE_ITEM || last_item);
  assign next_cnt = cnt_reg - dma_arb_pkg::ONE_ITEM;
  assign hw_clr = ((burst_end && last_item) ? (NUM_CH'(1) << dma_channel) : '0)
                | ((grant_fire && empty_ch) ? win_onehot : '0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      dma_channel <= dma_arb_pkg::RST_CH;
      ctl_reg <= dma_arb_pkg::RST_WORD;
      cnt_reg <= dma_arb_pkg::RST_CNT;
      burst_left_reg <= dma_arb_pkg::RST_CNT;
      dma_src_addr <= dma_arb_pkg::RST_WORD;
      dma_dst_addr <= dma_arb_pkg::RST_WORD;
      dma_size <= dma_arb_pkg::SIZE_BYTE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (grant_fire && !empty_ch) begin
            state_reg <= ST_RUN;
            dma_channel <= win;
            ctl_reg <= ctl_mem[win];
            cnt_reg <= win_cnt;
            dma_src_addr <= src_mem[win];
            dma_dst_addr <= dst_mem[win];
            dma_size <= ctl_mem[win][dma_arb_pkg::CTL_DSIZE_LSB +: 2];
            if (!use_burst) begin
              burst_left_reg <= dma_arb_pkg::ONE_ITEM;
            end else if (arb_items < win_cnt) begin
              burst_left_reg <= arb_items;
            end else begin
              burst_left_reg <= win_cnt;
            end
          end
        end
        ST_RUN: begin
          if (move) begin
            dma_src_addr <= dma_src_addr + step_of(ctl_reg[dma_arb_pkg::CTL_SINC_LSB +: 2]);
            dma_dst_addr <= dma_dst_addr + step_of(ctl_reg[dma_arb_pkg::CTL_DINC_LSB +: 2]);
            cnt_reg <= next_cnt;
            burst_left_reg <= burst_left_reg - dma_arb_pkg::ONE_ITEM;
            if (burst_end) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Channel table: burst write-back has priority over any software write to the table in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        src_mem[i] <= dma_arb_pkg::RST_WORD;
        dst_mem[i] <= dma_arb_pkg::RST_WORD;
        ctl_mem[i] <= dma_arb_pkg::RST_WORD;
      end
    end else if (burst_end) begin
      src_mem[dma_channel] <= dma_src_addr + step_of(ctl_reg[dma_arb_pkg::CTL_SINC_LSB +: 2]);
      dst_mem[dma_channel] <= dma_dst_addr + step_of(ctl_reg[dma_arb_pkg::CTL_DINC_LSB +: 2]);
      ctl_mem[dma_channel][dma_arb_pkg::CTL_CNT_LSB +: dma_arb_pkg::CTL_CNT_W] <= next_cnt;
    end else if (reg_wr) begin
      if (reg_addr == dma_arb_pkg::OFF_CH_SRC) begin
        src_mem[ch_sel_reg] <= reg_wdata;
      end else if (reg_addr == dma_arb_pkg::OFF_CH_DST) begin
        dst_mem[ch_sel_reg] <= reg_wdata;
      end else if (reg_addr == dma_arb_pkg::OFF_CH_CTRL) begin
        ctl_mem[ch_sel_reg] <= reg_wdata;
      end
    end
  end

  // Set-type writes win over hardware clears landing in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_reg <= '0;
      sw_pend_reg <= '0;
      done_reg <= '0;
      done_pulse <= '0;
    end else begin
      enable_reg <= (enable_reg & ~hw_clr
                    & ~((reg_wr && reg_addr == dma_arb_pkg::OFF_ENA_CLR) ? reg_wdata : '0))
                    | ((reg_wr && reg_addr == dma_arb_pkg::OFF_ENA_SET) ? reg_wdata : '0);
      sw_pend_reg <= (sw_pend_reg & ~(grant_fire ? win_onehot : '0))
                    | ((reg_wr && reg_addr == dma_arb_pkg::OFF_SW_REQ) ? reg_wdata : '0);
      done_pulse <= hw_clr;
      done_reg <= (done_reg & ~((reg_wr && reg_addr == dma_arb_pkg::OFF_DONE) ? reg_wdata : '0))
                  | hw_clr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prio_reg <= '0;
      burst_only_reg <= '0;
      mask_reg <= '0;
      ch_sel_reg <= dma_arb_pkg::RST_CH;
    end else if (reg_wr) begin
      if (reg_addr == dma_arb_pkg::OFF_PRIO_SET) begin
        prio_reg <= prio_reg | reg_wdata;
      end else if (reg_addr == dma_arb_pkg::OFF_PRIO_CLR) begin
        prio_reg <= prio_reg & ~reg_wdata;
      end else if (reg_addr == dma_arb_pkg::OFF_BURST_SET) begin
        burst_only_reg <= burst_only_reg | reg_wdata;
      end else if (reg_addr == dma_arb_pkg::OFF_BURST_CLR) begin
        burst_only_reg <= burst_only_reg & ~reg_wdata;
      end else if (reg_addr == dma_arb_pkg::OFF_MASK_SET) begin
        mask_reg <= mask_reg | reg_wdata;
      end else if (reg_addr == dma_arb_pkg::OFF_MASK_CLR) begin
        mask_reg <= mask_reg & ~reg_wdata;
      end else if (reg_addr == dma_arb_pkg::OFF_CH_SEL) begin
        ch_sel_reg <= reg_wdata[4:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= dma_arb_pkg::RST_WORD;
    end else if (!reg_rd) begin
      reg_rdata <= dma_arb_pkg::RST_WORD;
    end else if (reg_addr == dma_arb_pkg::OFF_ENA_SET) begin
      reg_rdata <= enable_reg;
    end else if (reg_addr == dma_arb_pkg::OFF_PRIO_SET) begin
      reg_rdata <= prio_reg;
    end else if (reg_addr == dma_arb_pkg::OFF_BURST_SET) begin
      reg_rdata <= burst_only_reg;
    end else if (reg_addr == dma_arb_pkg::OFF_MASK_SET) begin
      reg_rdata <= mask_reg;
    end else if (reg_addr == dma_arb_pkg::OFF_SW_REQ) begin
      reg_rdata <= sw_pend_reg;
    end else if (reg_addr == dma_arb_pkg::OFF_DONE) begin
      reg_rdata <= done_reg;
    end else if (reg_addr == dma_arb_pkg::OFF_CH_SEL) begin
      reg_rdata <= {27'h0000000, ch_sel_reg};
    end else if (reg_addr == dma_arb_pkg::OFF_CH_SRC) begin
      reg_rdata <= src_mem[ch_sel_reg];
    end else if (reg_addr == dma_arb_pkg::OFF_CH_DST) begin
      reg_rdata <= dst_mem[ch_sel_reg];
    end else if (reg_addr == dma_arb_pkg::OFF_CH_CTRL) begin
      reg_rdata <= ctl_mem[ch_sel_reg];
    end else if (reg_addr == dma_arb_pkg::OFF_STATUS) begin
      reg_rdata <= {15'h0000, cnt_reg, dma_channel, state_reg == ST_RUN};
    end else begin
      reg_rdata <= dma_arb_pkg::RST_WORD;
    end
  end

  a_cpu_stalls_dma: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_bus_req |-> !dma_bus_valid) else $error("dma moved an item while the cpu held the bus");
  a_stall_keeps_item: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == ST_RUN && cpu_bus_req) |=> (state_reg == ST_RUN && $stable(cnt_reg)))
    else $error("stalled item was lost");
  a_high_beats_default: assert property (@(posedge clk) disable iff (sys_rst)
    (grant_fire && !prio_reg[win]) |-> (eff_req & prio_reg) == '0)
    else $error("default channel granted over high priority");
  a_low_number_wins: assert property (@(posedge clk) disable iff (sys_rst)
    grant_fire |-> (eff_req & (win_onehot - NUM_CH'(1))
                    & (prio_reg[win] ? prio_reg : ~prio_reg)) == '0)
    else $error("higher numbered channel won in its level");
  a_single_one_item: assert property (@(posedge clk) disable iff (sys_rst)
    (grant_fire && !empty_ch && !use_burst) |=> burst_left_reg == dma_arb_pkg::ONE_ITEM)
    else $error("single request did not move one item");
  a_burst_min_len: assert property (@(posedge clk) disable iff (sys_rst)
    (grant_fire && !empty_ch && use_burst) |=>
      burst_left_reg == (($past(arb_items) < $past(win_cnt)) ? $past(arb_items) : $past(win_cnt)))
    else $error("burst length is not min of arbitration size and count");
  a_burst_only_mute: assert property (@(posedge clk) disable iff (sys_rst)
    grant_fire |-> !(burst_only_reg[win] && !burst_sync[win] && !sw_pend_reg[win]))
    else $error("single request served on burst-only channel");
  a_mask_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    grant_fire |-> (!mask_reg[win] || sw_pend_reg[win])) else $error("masked request granted");
  a_done_disables: assert property (@(posedge clk) disable iff (sys_rst)
    (burst_end && last_item) |=> done_pulse[$past(dma_channel)]
      && (!enable_reg[$past(dma_channel)]
          || $past(reg_wr && reg_addr == dma_arb_pkg::OFF_ENA_SET)))
    else $error("completed channel stayed enabled");
  a_rearbitrate: assert property (@(posedge clk) disable iff (sys_rst)
    burst_end |=> state_reg == ST_IDLE) else $error("no arbitration after burst");
  a_prio_set_bit: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == dma_arb_pkg::OFF_PRIO_SET)
      |=> (prio_reg & $past(reg_wdata)) == $past(reg_wdata))
    else $error("priority set write lost");
endmodule : dma_channel_arbiter

// [dv/periph_model.sv]
`timescale 1ns/1ps
module periph_model #(
  parameter int THR = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [4:0] load_ch,
  input wire logic [7:0] load_n,
  input wire logic dma_bus_valid,
  input wire logic [4:0] dma_channel,
  output logic [31:0] single_req,
  output logic [31:0] burst_req
);
  logic [7:0] avail_reg [32];
  // Each item moved for a channel drains one entry of that peripheral's FIFO.
  always_ff @(posedge clk) begin
    for (int c = 0; c < 32; c++) begin
      if (sys_rst) begin
        avail_reg[c] <= 8'h00;
      end else if (load && load_ch == 5'(c)) begin
        avail_reg[c] <= load_n;
      end else if (dma_bus_valid && dma_channel == 5'(c) && avail_reg[c] != 8'h00) begin
        avail_reg[c] <= avail_reg[c] - 8'h01;
      end
    end
  end
  // Endpoints on channels 0 to 5 have no single request line.
  always_comb begin
    for (int c = 0; c < 32; c++) begin
      single_req[c] = (c > 5) && (avail_reg[c] != 8'h00);
      burst_req[c] = (avail_reg[c] >= 8'(THR));
    end
  end
endmodule : periph_model

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk, sys_rst, reg_wr, reg_rd, cpu_bus_req, dma_bus_valid, stall_en, load;
  logic [7:0] reg_addr, load_n;
  logic [31:0] reg_wdata, reg_rdata, single_req, burst_req, dma_src_addr, dma_dst_addr;
  logic [31:0] done_pulse;
  logic [1:0] dma_size;
  logic [4:0] dma_channel, load_ch;
  int failures, samples_checked, seed, moved[32], dones[32], order[$];
  logic [31:0] exp_src[32], exp_dst[32];
  logic [1:0] exp_size[32], sinc[32];

  dma_channel_arbiter dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .single_req(single_req), .burst_req(burst_req), .cpu_bus_req(cpu_bus_req),
    .dma_bus_valid(dma_bus_valid), .dma_src_addr(dma_src_addr),
    .dma_dst_addr(dma_dst_addr), .dma_size(dma_size), .dma_channel(dma_channel),
    .done_pulse(done_pulse));
  periph_model #(.THR(4)) periph_u (.clk(clk), .sys_rst(sys_rst), .load(load),
    .load_ch(load_ch), .load_n(load_n), .dma_bus_valid(dma_bus_valid),
    .dma_channel(dma_channel), .single_req(single_req), .burst_req(burst_req));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] step(input logic [1:0] i);
    return (i == 2'h3) ? 32'h0 : 32'h1 << i;
  endfunction : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Processor traffic is random so stalls land mid-burst as well as between bursts.
  always @(posedge clk) begin
    cpu_bus_req <= stall_en && (($random(seed) & 3) == 0);
  end

  always @(posedge clk) begin
    if (!sys_rst && cpu_bus_req) chk({31'h0, dma_bus_valid}, 32'h0);
    if (!sys_rst && dma_bus_valid) begin
      moved[dma_channel]++;
      order.push_back(int'(dma_channel));
      chk(dma_src_addr, exp_src[dma_channel]);
      chk(dma_dst_addr, exp_dst[dma_channel]);
      chk({30'h0, dma_size}, {30'h0, exp_size[dma_channel]});
      exp_src[dma_channel] += step(sinc[dma_channel]);
      exp_dst[dma_channel] += step(~sinc[dma_channel]);
    end
    for (int c = 0; c < 32; c++) if (!sys_rst && done_pulse[c]) dones[c]++;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic settle();
    int q;
    q = 0;
    for (int i = 0; i < 4000 && q < 30; i++) begin
      @(negedge clk);
      q = dma_bus_valid ? 0 : q + 1;
    end
    if (q < 30) failures++;
  endtask : settle

  task automatic cfg(input int ch, input logic [1:0] sz, input logic [1:0] inc,
                     input int arb, input int cnt);
    wr(dma_arb_pkg::OFF_CH_SEL, 32'(ch));
    wr(dma_arb_pkg::OFF_CH_SRC, 32'h2000_0000 + 32'(ch * 256));
    wr(dma_arb_pkg::OFF_CH_DST, 32'h4000_0000);
    wr(dma_arb_pkg::OFF_CH_CTRL, {5'h00, 11'(cnt), 10'(arb - 1), ~inc, inc, sz});
    exp_src[ch] = 32'h2000_0000 + 32'(ch * 256);
    exp_dst[ch] = 32'h4000_0000;
    exp_size[ch] = sz;
    sinc[ch] = inc;
    moved[ch] = 0;
    dones[ch] = 0;
    wr(dma_arb_pkg::OFF_ENA_SET, 32'h1 << ch);
  endtask : cfg

  task automatic feed(input int ch, input int n);
    @(posedge clk);
    load <= 1'b1;
    load_ch <= 5'(ch);
    load_n <= 8'(n);
    @(posedge clk);
    load <= 1'b0;
    settle();
  endtask : feed

  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] r, v;
    int a, c, ch;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    stall_en = 1'b0;
    load = 1'b0;
    load_ch = 5'h00;
    load_n = 8'h00;
    seed = 32'h2A14;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(dma_arb_pkg::OFF_PRIO_SET, r);
    chk(r, 32'h0);
    rd(8'hFC, r);
    chk(r, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(dma_arb_pkg::OFF_PRIO_SET, v);
      rd(dma_arb_pkg::OFF_PRIO_SET, r);
      chk(r, v);
      wr(dma_arb_pkg::OFF_PRIO_CLR, v);
      rd(dma_arb_pkg::OFF_PRIO_SET, r);
      chk(r, 32'h0);
    end
    stall_en = 1'b1;
    // The last pass uses the largest arbitration size against a short count.
    for (int i = 0; i < 5; i++) begin
      ch = 12 + i;
      a = (i == 4) ? 1024 : 1 + ($random(seed) & 3);
      c = 2 + ($random(seed) & 3);
      cfg(ch, 2'(i % 3), 2'(i), a, c);
      wr(dma_arb_pkg::OFF_SW_REQ, 32'h1 << ch);
      settle();
      chk(32'(moved[ch]), 32'((a < c) ? a : c));
      chk(32'(dones[ch]), 32'(a >= c));
      rd(dma_arb_pkg::OFF_ENA_SET, r);
      chk({31'h0, r[ch]}, 32'(a < c));
      rd(dma_arb_pkg::OFF_CH_CTRL, r);
      chk({21'h0, r[26:16]}, 32'(c - ((a < c) ? a : c)));
      rd(dma_arb_pkg::OFF_STATUS, r);
      chk({26'h0, r[5:0]}, {26'h0, 5'(ch), 1'b0});
      rd(dma_arb_pkg::OFF_DONE, r);
      chk({31'h0, r[ch]}, 32'(a >= c));
      wr(dma_arb_pkg::OFF_DONE, 32'h1 << ch);
      wr(dma_arb_pkg::OFF_ENA_CLR, 32'h1 << ch);
      rd(dma_arb_pkg::OFF_DONE, r);
      chk({31'h0, r[ch]}, 32'h0);
      rd(dma_arb_pkg::OFF_ENA_SET, r);
      chk({31'h0, r[ch]}, 32'h0);
    end
    stall_en = 1'b0;
    for (int p = 0; p < 2; p++) begin
      cfg(20, dma_arb_pkg::SIZE_WORD, dma_arb_pkg::INC_WORD, 1, 2);
      cfg(25, dma_arb_pkg::SIZE_WORD, dma_arb_pkg::INC_WORD, 1, 2);
      if (p == 1) wr(dma_arb_pkg::OFF_PRIO_SET, 32'h1 << 25);
      order.delete();
      wr(dma_arb_pkg::OFF_SW_REQ, (32'h1 << 20) | (32'h1 << 25));
      settle();
      chk(32'(order.size()), 32'h2);
      chk(32'(order[0]), (p == 1) ? 32'h19 : 32'h14);
    end
    stall_en = 1'b1;
    cfg(8, dma_arb_pkg::SIZE_BYTE, dma_arb_pkg::INC_NONE, 3, 10);
    feed(8, 2);
    chk(32'(moved[8]), 32'h2);
    feed(8, 5);
    chk(32'(moved[8]), 32'h7);
    cfg(9, dma_arb_pkg::SIZE_HALF, dma_arb_pkg::INC_HALF, 3, 10);
    wr(dma_arb_pkg::OFF_BURST_SET, 32'h1 << 9);
    feed(9, 2);
    chk(32'(moved[9]), 32'h0);
    feed(9, 4);
    chk(32'(moved[9]), 32'h3);
    wr(dma_arb_pkg::OFF_BURST_CLR, 32'h1 << 9);
    settle();
    chk(32'(moved[9]), 32'h4);
    cfg(10, dma_arb_pkg::SIZE_BYTE, dma_arb_pkg::INC_BYTE, 3, 10);
    wr(dma_arb_pkg::OFF_MASK_SET, 32'h1 << 10);
    feed(10, 2);
    chk(32'(moved[10]), 32'h0);
    wr(dma_arb_pkg::OFF_MASK_CLR, 32'h1 << 10);
    settle();
    chk(32'(moved[10]), 32'h2);
    tally_and_finish();
  end
endmodule : tb
